//--- core/card_socket_wake_width_regs.v
// Card socket register bank: programming-voltage decode, wake mask and status, access width.
`timescale 1ns/1ps
`include "card_socket_consts.vh"
module card_socket_wake_width_regs (
  input  wire        sys_clk_in,                // System clock, 10 MHz.
  input  wire        rst_n_in,                  // Asynchronous reset, active low.
  // APB slave.
  input  wire        psel_in,                   // APB select.
  input  wire        penable_in,                // APB access phase.
  input  wire        pwrite_in,                 // APB direction, high for write.
  input  wire [7:0]  paddr_in,                  // APB byte address.
  input  wire [31:0] pwdata_in,                 // APB write data.
  output reg  [31:0] prdata_out,                // APB read data.
  output reg         pready_out,                // APB ready.
  output reg         pslverr_out,               // APB error for unmapped address.
  // System I/O write path.
  input  wire        sys_io_wr_in,              // One-cycle system I/O write strobe.
  input  wire [7:0]  sys_addr_9_to_2_in,        // System address bits 9 down to 2.
  input  wire        sys_data0_in,              // System data bus bit 0.
  output reg         socket_a_prog_voltage_pin_out, // Socket A programming-voltage pin.
  // Wake sources.
  input  wire        uart_ring_in,              // Internal UART ring indicate.
  input  wire        rtc_irq8_in,               // Real-time clock interrupt, IRQ8.
  input  wire        irq4_in,                   // IRQ4 line.
  input  wire        irq3_in,                   // IRQ3 line.
  input  wire        sock_b_batt_detect1_pin_in, // Socket B battery-detect-1 ring pin.
  input  wire        sock_a_batt_detect1_pin_in, // Socket A battery-detect-1 ring pin.
  input  wire        sock_b_io_card_in,         // Socket B configured as I/O card.
  input  wire        sock_a_io_card_in,         // Socket A configured as I/O card.
  output reg         wake_event_out,            // One-cycle wake request to the power manager.
  output reg         sock_b_status_change_irq_en_out, // Socket B status-change irq allowed.
  output reg         sock_a_status_change_irq_en_out, // Socket A status-change irq allowed.
  // Card cycle translation.
  input  wire        xlat_req_in,               // One-cycle system access request.
  input  wire        xlat_sock_b_in,            // Access targets socket B.
  input  wire        xlat_is_io_in,             // Access is I/O, else memory.
  input  wire        xlat_wide_in,              // Access is 16-bit.
  input  wire        xlat_write_in,             // Access is a write.
  input  wire        xlat_addr0_in,             // System address bit 0.
  input  wire        sock_a_card_wide_io_ind_in, // Socket A card 16-bit I/O indication.
  input  wire        sock_b_card_wide_io_ind_in, // Socket B card 16-bit I/O indication.
  output reg         xlat_busy_out,             // Second card cycle pending.
  output reg         xlat_valid_out,            // One-cycle card cycle issue.
  output reg         xlat_sock_b_out,           // Card cycle goes to socket B.
  output reg         xlat_low_enable_out,       // Card low byte enable.
  output reg         xlat_high_enable_out,      // Card high byte enable.
  output reg         xlat_addr0_out,            // Card address bit 0.
  output reg         xlat_last_out,             // Last card cycle of the access.
  output reg         xlat_error_out             // Invalid selector or odd 16-bit I/O.
);
  reg  [7:0] prog_voltage_io_address_q;
  reg  [7:0] wake_source_mask_q;
  reg  [7:0] wake_source_status_q;
  reg  [7:0] card_access_width_q;
  reg  [7:0] wake_source_status_d;
  reg        prog_addr_loaded_q;
  reg  [7:0] rd_mux;
  reg        addr_hit;
  wire       apb_setup;
  wire       apb_write;
  wire [5:0] wake_src;
  wire [5:0] wake_en;
  wire [5:0] wake_ev;

  assign apb_setup = psel_in && !penable_in;
  assign apb_write = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;

  // Read mux and decode; reserved status bits read as zero.
  always @* begin
    rd_mux   = 8'h00;
    addr_hit = 1'b1;
    case (paddr_in)
      `ADDR_PROG_VOLT:    rd_mux = prog_voltage_io_address_q;
      `ADDR_WAKE_MASK:    rd_mux = wake_source_mask_q;
      `ADDR_WAKE_STATUS:  rd_mux = wake_source_status_q;
      `ADDR_ACCESS_WIDTH: rd_mux = card_access_width_q;
      default:            addr_hit = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle so that pready rises with penable: no wait state.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (apb_setup) begin
      prdata_out  <= {24'h000000, rd_mux};
      pready_out  <= 1'b1;
      pslverr_out <= !addr_hit;
    end else if (psel_in && penable_in && pready_out) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Control registers.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prog_voltage_io_address_q <= `RST_PROG_VOLT;
      prog_addr_loaded_q        <= 1'b0;
      wake_source_mask_q        <= `RST_WAKE_MASK;
      card_access_width_q       <= `RST_ACCESS_WIDTH;
    end else if (apb_write) begin
      case (paddr_in)
        `ADDR_PROG_VOLT: begin
          prog_voltage_io_address_q <= pwdata_in[7:0];
          prog_addr_loaded_q        <= 1'b1;
        end
        `ADDR_WAKE_MASK:    wake_source_mask_q  <= pwdata_in[7:0];
        `ADDR_ACCESS_WIDTH: card_access_width_q <= pwdata_in[7:0];
        default: begin
        end
      endcase
    end
  end

  // Programming-voltage pin follows data bit 0 on any decoded I/O write after loading.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      socket_a_prog_voltage_pin_out <= 1'b0;
    end else if (sys_io_wr_in && prog_addr_loaded_q &&
                 sys_addr_9_to_2_in == prog_voltage_io_address_q) begin
      socket_a_prog_voltage_pin_out <= sys_data0_in;
    end
  end

  // Wake sources in status bit order: 5 UART ring down to 0 socket A ring.
  assign wake_src = {uart_ring_in, rtc_irq8_in, irq4_in, irq3_in,
                     sock_b_batt_detect1_pin_in, sock_a_batt_detect1_pin_in};
  assign wake_en[5] = !wake_source_mask_q[`MSK_UART_RING];
  assign wake_en[4] = !wake_source_mask_q[`MSK_RTC];
  assign wake_en[3] = !wake_source_mask_q[`MSK_IRQ4];
  assign wake_en[2] = !wake_source_mask_q[`MSK_IRQ3];
  assign wake_en[1] = !wake_source_mask_q[`MSK_SOCK_B_BATT] &&
                      wake_source_mask_q[`MSK_SOCK_B_RING_SEL] && sock_b_io_card_in;
  assign wake_en[0] = !wake_source_mask_q[`MSK_SOCK_A_BATT] &&
                      wake_source_mask_q[`MSK_SOCK_A_RING_SEL] && sock_a_io_card_in;

  // Socket ring pins wake on a falling edge, the rest on a rising edge.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_wake
      wake_edge_latch #(
        .FALLING (gi < 2 ? 1 : 0)
      ) u_edge (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .src_in     (wake_src[gi]),
        .enable_in  (wake_en[gi]),
        .event_out  (wake_ev[gi])
      );
    end
  endgenerate

  // A wake arriving with the clearing write still records: set wins over clear.
  always @* begin
    wake_source_status_d = wake_source_status_q;
    if (apb_write && paddr_in == `ADDR_WAKE_STATUS && pwdata_in[7:0] == `STATUS_CLEAR_VAL) begin
      wake_source_status_d = `RST_WAKE_STATUS;
    end
    wake_source_status_d = (wake_source_status_d | {2'b00, wake_ev}) & `STATUS_USED_MASK;
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_source_status_q            <= `RST_WAKE_STATUS;
      wake_event_out                  <= 1'b0;
      sock_b_status_change_irq_en_out <= 1'b0;
      sock_a_status_change_irq_en_out <= 1'b0;
    end else begin
      wake_source_status_q            <= wake_source_status_d;
      wake_event_out                  <= |wake_ev;
      sock_b_status_change_irq_en_out <= !wake_source_mask_q[`MSK_SOCK_B_RING_SEL];
      sock_a_status_change_irq_en_out <= !wake_source_mask_q[`MSK_SOCK_A_RING_SEL];
    end
  end

  // Card cycle translation.
  reg  [1:0] io_sel;
  reg        wide_io_ok;
  reg        wide_mem_ok;
  reg        card_ind;
  reg        plan_split;
  reg        plan_low;
  reg        plan_high;
  reg        plan_err;
  reg        second_pending_q;
  reg        second_sock_b_q;

  always @* begin
    io_sel      = xlat_sock_b_in ?
                  {card_access_width_q[`WID_B_SEL_HI], card_access_width_q[`WID_B_SEL_LO]} :
                  {card_access_width_q[`WID_A_SEL_HI], card_access_width_q[`WID_A_SEL_LO]};
    wide_io_ok  = xlat_sock_b_in ? card_access_width_q[`WID_B_WIDE_IO] :
                                   card_access_width_q[`WID_A_WIDE_IO];
    wide_mem_ok = xlat_sock_b_in ? card_access_width_q[`WID_B_WIDE_MEM] :
                                   card_access_width_q[`WID_A_WIDE_MEM];
    card_ind    = xlat_sock_b_in ? sock_b_card_wide_io_ind_in : sock_a_card_wide_io_ind_in;
    plan_split  = 1'b0;
    plan_low    = 1'b1;
    plan_high   = 1'b0;
    plan_err    = 1'b0;
    if (!xlat_is_io_in) begin
      if (xlat_wide_in) begin
        // Only wide writes go out as one cycle; wide reads stay byte by byte.
        if (wide_mem_ok && xlat_write_in) begin
          plan_high = 1'b1;
        end else begin
          plan_split = 1'b1;
        end
      end else begin
        plan_low  = !xlat_addr0_in;
        plan_high = xlat_addr0_in;
      end
    end else if (!wide_io_ok) begin
      plan_split = xlat_wide_in;
    end else begin
      // An invalid selector is flagged and the access falls back to byte cycles.
      plan_err = (io_sel != `IO_SEL_VALID);
      if (plan_err || card_ind) begin
        plan_split = xlat_wide_in;
      end else if (xlat_wide_in) begin
        plan_high = 1'b1;
        plan_err  = xlat_addr0_in;
      end else begin
        plan_low  = !xlat_addr0_in;
        plan_high = xlat_addr0_in;
      end
    end
  end

  // A split access issues its second byte on the very next cycle; requests in between are lost.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      second_pending_q     <= 1'b0;
      second_sock_b_q      <= 1'b0;
      xlat_busy_out        <= 1'b0;
      xlat_valid_out       <= 1'b0;
      xlat_sock_b_out      <= 1'b0;
      xlat_low_enable_out  <= 1'b0;
      xlat_high_enable_out <= 1'b0;
      xlat_addr0_out       <= 1'b0;
      xlat_last_out        <= 1'b0;
      xlat_error_out       <= 1'b0;
    end else if (second_pending_q) begin
      second_pending_q     <= 1'b0;
      xlat_busy_out        <= 1'b0;
      xlat_valid_out       <= 1'b1;
      xlat_sock_b_out      <= second_sock_b_q;
      xlat_low_enable_out  <= 1'b1;
      xlat_high_enable_out <= 1'b0;
      xlat_addr0_out       <= 1'b1;
      xlat_last_out        <= 1'b1;
      xlat_error_out       <= 1'b0;
    end else if (xlat_req_in) begin
      second_pending_q     <= plan_split;
      second_sock_b_q      <= xlat_sock_b_in;
      xlat_busy_out        <= plan_split;
      xlat_valid_out       <= 1'b1;
      xlat_sock_b_out      <= xlat_sock_b_in;
      xlat_low_enable_out  <= plan_low;
      xlat_high_enable_out <= plan_high;
      xlat_addr0_out       <= plan_split ? 1'b0 : xlat_addr0_in;
      xlat_last_out        <= !plan_split;
      xlat_error_out       <= plan_err;
    end else begin
      xlat_valid_out       <= 1'b0;
      xlat_last_out        <= 1'b0;
      xlat_error_out       <= 1'b0;
    end
  end
endmodule

//--- core/card_socket_consts.vh
// Register offsets, field positions and reset values for the card socket block.
`ifndef CARD_SOCKET_CONSTS_VH
`define CARD_SOCKET_CONSTS_VH

`define IDX_PROG_VOLT     8'h07
`define IDX_WAKE_MASK     8'h08
`define IDX_WAKE_STATUS   8'h09
`define IDX_ACCESS_WIDTH  8'h0a
`define ADDR_PROG_VOLT    8'h1c
`define ADDR_WAKE_MASK    8'h20
`define ADDR_WAKE_STATUS  8'h24
`define ADDR_ACCESS_WIDTH 8'h28

`define RST_PROG_VOLT     8'h00
`define RST_WAKE_MASK     8'h00
`define RST_WAKE_STATUS   8'h00
`define RST_ACCESS_WIDTH  8'h00
`define STATUS_CLEAR_VAL  8'h00
`define STATUS_USED_MASK  8'h3f

`define MSK_SOCK_B_RING_SEL 7
`define MSK_SOCK_A_RING_SEL 6
`define MSK_UART_RING       5
`define MSK_RTC             4
`define MSK_IRQ4            3
`define MSK_IRQ3            2
`define MSK_SOCK_B_BATT     1
`define MSK_SOCK_A_BATT     0

`define WID_A_SEL_HI     7
`define WID_A_SEL_LO     6
`define WID_B_SEL_HI     5
`define WID_B_SEL_LO     4
`define WID_B_WIDE_IO    3
`define WID_A_WIDE_IO    2
`define WID_B_WIDE_MEM   1
`define WID_A_WIDE_MEM   0
`define IO_SEL_VALID     2'h2

`endif

//--- core/wake_edge_latch.v
// Edge detector that turns one wake source into a gated one-cycle event.
`timescale 1ns/1ps
module wake_edge_latch #(
  parameter FALLING = 0
) (
  input  wire sys_clk_in,   // System clock.
  input  wire rst_n_in,     // Asynchronous reset, active low.
  input  wire src_in,       // Wake source level.
  input  wire enable_in,    // Source allowed to wake.
  output reg  event_out     // One-cycle wake event.
);
  reg prev_q;
  reg armed_q;
  wire edge_seen;

  // Arming after reset keeps a level already active at reset from looking like an edge.
  assign edge_seen = armed_q && (FALLING ? (prev_q && !src_in) : (!prev_q && src_in));

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_q    <= 1'b0;
      armed_q   <= 1'b0;
      event_out <= 1'b0;
    end else begin
      prev_q    <= src_in;
      armed_q   <= 1'b1;
      event_out <= edge_seen && enable_in;
    end
  end
endmodule

//--- test/card_socket_sva.sv
// Concurrent checks on the ports of the card socket register bank.
`timescale 1ns/1ps
`include "card_socket_consts.vh"
module card_socket_sva (
  input wire logic       sys_clk_in, rst_n_in,                    // Clock and reset.
  input wire logic       psel_in, penable_in, pwrite_in, pready_out, // APB control.
  input wire logic [7:0]  paddr_in,                               // APB address.
  input wire logic [31:0] pwdata_in,                              // APB write data.
  input wire logic       sys_io_wr_in, sys_data0_in, socket_a_prog_voltage_pin_out, // I/O write.
  input wire logic [7:0]  sys_addr_9_to_2_in,                     // I/O address.
  input wire logic       irq3_in, irq4_in, rtc_irq8_in, uart_ring_in, wake_event_out, // Wake.
  input wire logic       sock_b_status_change_irq_en_out, sock_a_status_change_irq_en_out, // Irq.
  input wire logic       xlat_req_in, xlat_sock_b_in, xlat_is_io_in, xlat_wide_in, // Request.
  input wire logic       xlat_write_in, xlat_busy_out, xlat_valid_out, xlat_last_out, // Cycle.
  input wire logic       xlat_low_enable_out, xlat_high_enable_out, xlat_addr0_out // Enables.
);
  logic [7:0] msk_q, pv_q, wid_q;
  logic       armed_q;
  wire        wr_w = psel_in && penable_in && pready_out && pwrite_in;
  // Shadows follow completed APB writes so the checks know the programmed fields.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msk_q <= 8'h00; pv_q <= 8'h00; wid_q <= 8'h00; armed_q <= 1'b0;
    end else if (wr_w) begin
      if (paddr_in == `ADDR_PROG_VOLT) begin pv_q <= pwdata_in[7:0]; armed_q <= 1'b1; end
      if (paddr_in == `ADDR_WAKE_MASK) msk_q <= pwdata_in[7:0];
      if (paddr_in == `ADDR_ACCESS_WIDTH) wid_q <= pwdata_in[7:0];
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // The event passes the edge latch and then the output register, so it shows two edges later.
  irq3_wake_a: assert property ($rose(irq3_in) && !msk_q[2] |-> ##2 wake_event_out)
    else $error("irq3 edge gave no wake event");
  irq4_wake_a: assert property ($rose(irq4_in) && !msk_q[3] |-> ##2 wake_event_out)
    else $error("irq4 edge gave no wake event");
  rtc_wake_a: assert property ($rose(rtc_irq8_in) && !msk_q[4] |-> ##2 wake_event_out)
    else $error("rtc edge gave no wake event");
  uart_wake_a: assert property ($rose(uart_ring_in) && !msk_q[5] |-> ##2 wake_event_out)
    else $error("uart ring edge gave no wake event");
  ring_b_sel_a: assert property (wr_w && paddr_in == `ADDR_WAKE_MASK |-> ##2
    sock_b_status_change_irq_en_out == !msk_q[7]) else $error("socket b irq enable wrong");
  ring_a_sel_a: assert property (wr_w && paddr_in == `ADDR_WAKE_MASK |-> ##2
    sock_a_status_change_irq_en_out == !msk_q[6]) else $error("socket a irq enable wrong");
  pin_copy_a: assert property (sys_io_wr_in && armed_q && sys_addr_9_to_2_in == pv_q
    |=> socket_a_prog_voltage_pin_out == $past(sys_data0_in)) else $error("pin not copied");
  io_split_a: assert property (xlat_req_in && !xlat_busy_out && xlat_is_io_in && xlat_wide_in
    && !(xlat_sock_b_in ? wid_q[3] : wid_q[2]) |=> xlat_valid_out && !xlat_last_out
    ##1 xlat_valid_out && xlat_last_out && xlat_addr0_out) else $error("io access not split");
  mem_wide_a: assert property (xlat_req_in && !xlat_busy_out && !xlat_is_io_in && xlat_wide_in
    && xlat_write_in && (xlat_sock_b_in ? wid_q[1] : wid_q[0]) |=> xlat_valid_out && xlat_last_out
    && xlat_low_enable_out && xlat_high_enable_out) else $error("wide write not single");
  cover property (wake_event_out);
  cover property (xlat_valid_out && !xlat_last_out);
  cover property (wr_w && paddr_in == `ADDR_WAKE_STATUS);
endmodule

//--- test/card_socket_model.sv
// Behavioural pair of cards: ring on the battery-detect pins and 16-bit I/O indication.
`timescale 1ns/1ps
module card_socket_model (
  input  wire logic ring_a_in,  // Card A rings.
  input  wire logic ring_b_in,  // Card B rings.
  input  wire logic wide_io_in, // Cards report 16-bit I/O.
  output wire logic batt_a_out, // Socket A battery-detect-1 pin.
  output wire logic batt_b_out, // Socket B battery-detect-1 pin.
  output wire logic ind_a_out,  // Socket A 16-bit I/O indication.
  output wire logic ind_b_out   // Socket B 16-bit I/O indication.
);
  // The pin idles at the battery-good level, so only a ring gives a falling edge.
  assign batt_a_out = !ring_a_in;
  assign batt_b_out = !ring_b_in;
  assign ind_a_out  = wide_io_in;
  assign ind_b_out  = wide_io_in;
endmodule

//--- test/tb.sv
// Self-checking bench for the card socket register bank.
`timescale 1ns/1ps
`include "card_socket_consts.vh"
module tb;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, io_wr = 0, d0 = 0, dv, en, e;
  logic io_a = 0, io_b = 0, wide_ind = 0, xreq = 0, xsb = 0, xio = 0, xwd = 0, xw = 0, xa0 = 0;
  logic pready, pslverr, pin, wake, en_b, en_a, busy, valid, xb, lo, hi, a0o, last, err;
  logic batt_a, batt_b, ind_a, ind_b, armed_m = 0, pin_m = 0, wio, wm, a0, bad, ind, odd;
  logic [5:0]  src = 6'h00;
  logic [5:0]  q[$];
  logic [7:0]  paddr = 8'h00, saddr = 8'h00, mask_m = 8'h00, stat_m = 8'h00, wid_m = 8'h00;
  logic [7:0]  pv_m = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'd23, r, rd;
  integer      fail_count = 0, tests_run = 0, i, m, k, n, j;
  always #50 clk = ~clk;
  card_socket_wake_width_regs dut (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sys_io_wr_in(io_wr),
    .sys_addr_9_to_2_in(saddr), .sys_data0_in(d0), .socket_a_prog_voltage_pin_out(pin),
    .uart_ring_in(src[5]), .rtc_irq8_in(src[4]), .irq4_in(src[3]), .irq3_in(src[2]),
    .sock_b_batt_detect1_pin_in(batt_b), .sock_a_batt_detect1_pin_in(batt_a),
    .sock_b_io_card_in(io_b), .sock_a_io_card_in(io_a), .wake_event_out(wake),
    .sock_b_status_change_irq_en_out(en_b), .sock_a_status_change_irq_en_out(en_a),
    .xlat_req_in(xreq), .xlat_sock_b_in(xsb), .xlat_is_io_in(xio), .xlat_wide_in(xwd),
    .xlat_write_in(xw), .xlat_addr0_in(xa0), .sock_a_card_wide_io_ind_in(ind_a),
    .sock_b_card_wide_io_ind_in(ind_b), .xlat_busy_out(busy), .xlat_valid_out(valid),
    .xlat_sock_b_out(xb), .xlat_low_enable_out(lo), .xlat_high_enable_out(hi),
    .xlat_addr0_out(a0o), .xlat_last_out(last), .xlat_error_out(err));
  card_socket_model cards (.ring_a_in(src[0]), .ring_b_in(src[1]), .wide_io_in(wide_ind),
    .batt_a_out(batt_a), .batt_b_out(batt_b), .ind_a_out(ind_a), .ind_b_out(ind_b));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      `ADDR_PROG_VOLT:    return pv_m;
      `ADDR_WAKE_MASK:    return mask_m;
      `ADDR_WAKE_STATUS:  return stat_m;
      `ADDR_ACCESS_WIDTH: return wid_m;
      default:            return 8'h00;
    endcase
  endfunction
  task stop_test;
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The slave answers when it likes; only the bound on the wait ends it.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin fail_count++; stop_test; end
      @(posedge clk);
    end
    rd = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    if (a == `ADDR_PROG_VOLT) begin pv_m = d; armed_m = 1'b1; end
    if (a == `ADDR_WAKE_MASK) mask_m = d;
    if (a == `ADDR_WAKE_STATUS && d == 8'h00) stat_m = 8'h00;
    if (a == `ADDR_ACCESS_WIDTH) wid_m = d;
  endtask
  task rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, exp_reg(a)});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) rdc(8'(8'h1c + 4 * i));
    apb(1'b1, 8'h2c, 32'hff);
    apb(1'b0, 8'h2c, 32'h0);
    chk({rd[30:0], e}, 32'h1);
    // Before the address register is loaded a matching write must leave the pin alone.
    @(posedge clk); io_wr <= 1'b1; saddr <= 8'h00; d0 <= 1'b1;
    @(posedge clk); io_wr <= 1'b0;
    #1 chk(pin, 1'b0);
    for (i = 0; i < 4; i++) begin
      r = xs();
      wr(8'(8'h1c + 4 * i), r[7:0]);
      rdc(8'(8'h1c + 4 * i));
    end
    for (k = 0; k < 10; k++) begin
      r = xs();
      if (k == 2) wr(`ADDR_PROG_VOLT, r[15:8]);
      dv = r[16] | (k == 1);
      @(posedge clk); io_wr <= 1'b1; saddr <= k[0] ? pv_m : r[7:0]; d0 <= dv;
      @(posedge clk); io_wr <= 1'b0;
      if (armed_m && (k[0] || r[7:0] == pv_m)) pin_m = dv;
      #1 chk(pin, pin_m);
    end
    for (i = 0; i < 6; i++) begin
      for (m = 0; m < 4; m++) begin
        if (m == 0 && i == 3) begin wr(`ADDR_WAKE_STATUS, 8'h3f); wr(`ADDR_WAKE_STATUS, 8'h00); end
        wr(`ADDR_WAKE_MASK, (m == 2) ? 8'h00 : ((m == 1) ? (8'hc0 | (8'h01 << i)) : 8'hc0));
        io_a <= (m != 3); io_b <= (m != 3);
        en = (m == 0) || (i > 1 && m != 1);
        @(posedge clk); src[i] <= 1'b1;
        j = 0;
        repeat (5) begin @(posedge clk); #1; if (wake === 1'b1) j++; end
        src[i] <= 1'b0;
        repeat (4) @(posedge clk);
        chk({en_b, en_a}, {~mask_m[7], ~mask_m[6]});
        if (en) stat_m = stat_m | (8'h01 << i);
        chk(j, en);
        rdc(`ADDR_WAKE_STATUS);
      end
    end
    for (k = 0; k < 48; k++) begin
      r = xs();
      wr(`ADDR_ACCESS_WIDTH, {k[2] ? r[13:10] : 4'ha, r[9:6]});
      wio = r[0] ? wid_m[3] : wid_m[2];
      wm = r[0] ? wid_m[1] : wid_m[0];
      a0 = r[4] & (~r[2] | r[1]);
      // A bad selector is flagged and falls back to byte cycles, as a high indication would.
      bad = r[1] && wio && ((r[0] ? wid_m[5:4] : wid_m[7:6]) != `IO_SEL_VALID);
      ind = r[5] | bad;
      odd = r[1] && wio && !ind && a0;
      q = {};
      if (r[2] && (r[1] ? (!wio || ind) : !(wm && r[3]))) begin
        q.push_back({r[0], 4'b1000, bad});
        q.push_back({r[0], 5'b10110});
      end else if (r[2]) q.push_back({r[0], 2'b11, a0, 1'b1, odd});
      else if (r[1] && (!wio || ind)) q.push_back({r[0], 2'b10, a0, 1'b1, bad});
      else q.push_back({r[0], !a0, a0, a0, 2'b10});
      @(posedge clk);
      xreq <= 1'b1; xsb <= r[0]; xio <= r[1]; xwd <= r[2]; xw <= r[3]; xa0 <= a0; wide_ind <= r[5];
      @(posedge clk); xreq <= 1'b0; #1;
      repeat (4) begin
        if (valid === 1'b1) chk({xb, lo, hi, a0o, last, err}, (q.size() > 0) ? q.pop_front() : 6'h3f);
        chk(busy, q.size() != 0);
        @(posedge clk); #1;
      end
      chk(q.size(), 0);
    end
    stop_test;
  end
endmodule
bind card_socket_wake_width_regs card_socket_sva chk_i (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .pready_out(pready_out), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .sys_io_wr_in(sys_io_wr_in), .sys_data0_in(sys_data0_in),
  .socket_a_prog_voltage_pin_out(socket_a_prog_voltage_pin_out),
  .sys_addr_9_to_2_in(sys_addr_9_to_2_in), .irq3_in(irq3_in), .irq4_in(irq4_in),
  .rtc_irq8_in(rtc_irq8_in), .uart_ring_in(uart_ring_in), .wake_event_out(wake_event_out),
  .sock_b_status_change_irq_en_out(sock_b_status_change_irq_en_out),
  .sock_a_status_change_irq_en_out(sock_a_status_change_irq_en_out),
  .xlat_req_in(xlat_req_in), .xlat_sock_b_in(xlat_sock_b_in), .xlat_is_io_in(xlat_is_io_in),
  .xlat_wide_in(xlat_wide_in), .xlat_write_in(xlat_write_in), .xlat_busy_out(xlat_busy_out),
  .xlat_valid_out(xlat_valid_out), .xlat_last_out(xlat_last_out),
  .xlat_low_enable_out(xlat_low_enable_out), .xlat_high_enable_out(xlat_high_enable_out),
  .xlat_addr0_out(xlat_addr0_out));
